// *** design/wp_status_core.sv ***
// serial flash write-protection and status register block
`timescale 1ns/100ps
`default_nettype none
module wp_status_core
    import wp_status_pkg::*;
#(
    parameter int PUW_CYCLES  = wp_status_pkg::PUW_CYC,
    parameter int BUSY_CYCLES = wp_status_pkg::BUSY_CYC
) (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       arst_n,
    // serial interface pins
    input  wire logic                       sck,
    input  wire logic                       cs_n,
    input  wire logic                       si,
    output logic                            so,
    output logic                            so_oe,
    // protect and hold pins
    input  wire logic                       wp_n,
    input  wire logic                       hold_n,
    // non-volatile image kept across power cycles
    input  wire logic [15:0]                nv_image,
    output logic [15:0]                     nv_store,
    output logic                            nv_store_stb,
    // status and control towards the array engine
    output logic [15:0]                     status_word,
    output logic                            lane_mode_four,
    output logic                            array_op_stb,
    output logic [7:0]                      array_op_code,
    output logic [wp_status_pkg::ADDR_W-1:0] array_op_addr
);
    import wp_status_pkg::*;

    // reset release and pin synchronisers
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    logic sck_s;
    logic cs_n_s;
    logic si_s;
    logic wp_n_s;
    wp_sync2 u_sync_sck (.mclk(mclk), .rst_n(rst_n_q), .d(sck),    .q(sck_s));
    wp_sync2 u_sync_cs  (.mclk(mclk), .rst_n(rst_n_q), .d(~cs_n),  .q(cs_n_s));
    wp_sync2 u_sync_si  (.mclk(mclk), .rst_n(rst_n_q), .d(si),     .q(si_s));
    wp_sync2 u_sync_wp  (.mclk(mclk), .rst_n(rst_n_q), .d(wp_n),   .q(wp_n_s));

    logic sck_d1_q;
    logic sel_d1_q;
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sck_d1_q <= 1'b0;
            sel_d1_q <= 1'b0;
        end else begin
            sck_d1_q <= sck_s;
            sel_d1_q <= cs_n_s;
        end
    end
    logic sck_rise;
    logic sck_fall;
    logic frame_start;
    logic frame_end;
    assign sck_rise    = sck_s & ~sck_d1_q;
    assign sck_fall    = ~sck_s & sck_d1_q;
    assign frame_start = cs_n_s & ~sel_d1_q;
    assign frame_end   = ~cs_n_s & sel_d1_q;

    // power-up write delay and power-on state
    logic [CNT_W-1:0] puw_cnt_q;
    logic             puw_done_q;
    logic             nv_loaded_q;
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            puw_cnt_q  <= '0;
            puw_done_q <= 1'b0;
        end else if (!puw_done_q) begin
            puw_cnt_q  <= puw_cnt_q + CNT_W'(1);
            puw_done_q <= (puw_cnt_q >= CNT_W'(PUW_CYCLES - 1));
        end
    end

    // status register state
    logic [15:0] nv_q;
    logic        armed_q;
    logic        busy_q;
    logic        susp_q;
    logic        dpd_q;
    logic [1:0]  lock;
    assign lock = {nv_q[BIT_LOCK1], nv_q[BIT_LOCK0]};

    // frame decoder
    frame_st_t   st_q;
    logic [7:0]  sh_q;
    logic [2:0]  bit_q;
    logic [7:0]  op_q;
    logic [1:0]  bcnt_q;
    logic [23:0] addr_q;
    logic [15:0] wdata_q;
    logic [1:0]  wbytes_q;
    logic [7:0]  rd_q;
    logic        byte_done;
    logic [7:0]  byte_in;
    assign byte_done = sck_rise && (bit_q == 3'h7);
    assign byte_in   = {sh_q[6:0], si_s};

    // gating of an incoming opcode
    logic op_ok;
    always_comb begin
        op_ok = nv_loaded_q;
        if (dpd_q && byte_in != OP_RDPD) op_ok = 1'b0;
        // a suspended operation keeps busy up, so resume must get through
        if (busy_q && byte_in != OP_RDSR1 && byte_in != OP_RDSR2 && byte_in != OP_SUSP &&
            !(susp_q && byte_in == OP_RESUME))
            op_ok = 1'b0;
        if (!nv_q[BIT_FOUR] && (byte_in == OP_QPP || byte_in == OP_QREAD ||
            byte_in == OP_QIOREAD || byte_in == OP_QPI))
            op_ok = 1'b0;
    end

    logic is_write_op;
    assign is_write_op = (op_q == OP_PP) || (op_q == OP_QPP) || (op_q == OP_SE4) ||
                         (op_q == OP_BE32) || (op_q == OP_BE64) || (op_q == OP_WRSEC);

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q     <= ST_IDLE;
            sh_q     <= '0;
            bit_q    <= '0;
            op_q     <= '0;
            bcnt_q   <= '0;
            addr_q   <= '0;
            wdata_q  <= '0;
            wbytes_q <= '0;
        end else if (frame_start) begin
            st_q     <= ST_OP;
            bit_q    <= '0;
            bcnt_q   <= '0;
            wbytes_q <= '0;
        end else if (!cs_n_s) begin
            st_q <= ST_IDLE;
        end else if (sck_rise) begin
            sh_q  <= byte_in;
            bit_q <= bit_q + 3'h1;
            if (byte_done) begin
                unique case (st_q)
                    ST_OP: begin
                        op_q <= byte_in;
                        if (!op_ok)
                            st_q <= ST_SKIP;
                        else if (byte_in == OP_WRSR)
                            st_q <= ST_DATA;
                        else if (byte_in == OP_RDSR1 || byte_in == OP_RDSR2)
                            st_q <= ST_READ;
                        else
                            st_q <= ST_ADDR;
                    end
                    ST_ADDR: begin
                        addr_q <= {addr_q[15:0], byte_in};
                        bcnt_q <= bcnt_q + 2'h1;
                        if (bcnt_q == 2'h2) st_q <= ST_DATA;
                    end
                    ST_DATA: begin
                        if (wbytes_q == 2'h0) wdata_q[7:0] <= byte_in;
                        if (wbytes_q == 2'h1) wdata_q[15:8] <= byte_in;
                        if (wbytes_q != 2'h3) wbytes_q <= wbytes_q + 2'h1;
                    end
                    ST_READ, ST_SKIP, ST_IDLE: begin
                    end
                endcase
            end
        end
    end

    // read shifter, status presented on falling edges
    logic [15:0] status_now;
    assign status_now = {susp_q, nv_q[BIT_INVERT], 4'h0, nv_q[9:2], armed_q, busy_q};
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_q  <= '0;
            so    <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so_oe <= cs_n_s && (st_q == ST_READ);
            if (st_q == ST_READ && sck_fall) begin
                if (bit_q == 3'h0) begin
                    rd_q <= (op_q == OP_RDSR2) ? {status_now[14:8], 1'b0} : {status_now[6:0], 1'b0};
                    so   <= (op_q == OP_RDSR2) ? status_now[15] : status_now[7];
                end else begin
                    so   <= rd_q[7];
                    rd_q <= {rd_q[6:0], 1'b0};
                end
            end
        end
    end

    // end-of-frame decisions
    logic        wr_allowed;
    logic        frame_ok;
    logic [15:0] new_nv;
    logic        prot_hit;
    logic [ADDR_W-1:0] rng_lo;
    logic [ADDR_W-1:0] rng_hi;
    logic [ADDR_W-1:0] rng_mask;
    always_comb begin
        unique case (lock)
            LOCK_SW: wr_allowed = armed_q;
            LOCK_HW: wr_allowed = armed_q && wp_n_s;
            LOCK_PWR: wr_allowed = 1'b0;
            LOCK_OTP: wr_allowed = 1'b0;
        endcase
        if (nv_q[BIT_FOUR] && lock == LOCK_HW) wr_allowed = armed_q;
        frame_ok = (bit_q == 3'h0) && puw_done_q;
        new_nv   = (nv_q & ~NV_MASK) | ({wdata_q[15:8], wdata_q[7:0]} & NV_MASK);
        if (wbytes_q == 2'h1)
            new_nv = {nv_q[15:8], new_nv[7:0]};
        unique case (op_q)
            OP_SE4:  rng_mask = SEC4K_MASK;
            OP_BE32: rng_mask = BLK32K_MASK;
            OP_BE64: rng_mask = BLK64K_MASK;
            OP_CE:   rng_mask = ARRAY_TOP;
            default: rng_mask = '0;
        endcase
        rng_lo = addr_q[ADDR_W-1:0] & ~rng_mask;
        rng_hi = rng_lo | rng_mask;
    end

    wp_region_check u_region (
        .size_bits         (nv_q[BIT_SIZE_HI:BIT_SIZE_LO]),
        .bottom_select     (nv_q[BIT_BOTTOM]),
        .small_unit_select (nv_q[BIT_SMALL]),
        .invert_protection (nv_q[BIT_INVERT]),
        .lo_addr           (rng_lo),
        .hi_addr           (rng_hi),
        .hit               (prot_hit)
    );

    // operation timer drives busy
    logic [CNT_W-1:0] busy_cnt_q;
    logic             start_wrsr;
    logic             start_arr;
    assign start_wrsr = frame_end && st_q == ST_DATA && op_q == OP_WRSR && wbytes_q != 2'h0
                        && frame_ok && wr_allowed;
    assign start_arr  = frame_end && frame_ok && armed_q && !prot_hit &&
                        ((is_write_op && st_q == ST_DATA) ||
                         (op_q == OP_CE && st_q == ST_ADDR && bcnt_q == 2'h0));

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            busy_q     <= 1'b0;
            busy_cnt_q <= '0;
        end else if (start_wrsr || start_arr) begin
            busy_q     <= 1'b1;
            busy_cnt_q <= CNT_W'(BUSY_CYCLES - 1);
        end else if (busy_q && !susp_q) begin
            if (busy_cnt_q == '0)
                busy_q <= 1'b0;
            else
                busy_cnt_q <= busy_cnt_q - CNT_W'(1);
        end
    end

    // non-volatile bits and latch; the image is loaded after release
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            nv_q        <= NV_RESET;
            nv_loaded_q <= 1'b0;
            armed_q     <= 1'b0;
            susp_q      <= 1'b0;
            dpd_q       <= 1'b0;
        end else if (!nv_loaded_q) begin
            nv_q        <= nv_image & NV_MASK;
            if ({nv_image[BIT_LOCK1], nv_image[BIT_LOCK0]} == LOCK_PWR) begin
                nv_q[BIT_LOCK1] <= 1'b0;
                nv_q[BIT_LOCK0] <= 1'b0;
            end
            nv_loaded_q <= 1'b1;
        end else if (frame_end && st_q != ST_SKIP && st_q != ST_IDLE) begin
            if (start_wrsr) begin
                nv_q    <= new_nv;
                armed_q <= 1'b0;
            end else if (op_q == OP_WRSR || start_arr || (is_write_op && frame_ok)) begin
                armed_q <= 1'b0;
            end
            if (frame_ok && st_q == ST_ADDR && bcnt_q == 2'h0) begin
                if (op_q == OP_WREN && puw_done_q) armed_q <= 1'b1;
                if (op_q == OP_WRDI) armed_q <= 1'b0;
                if (op_q == OP_SUSP && busy_q) susp_q <= 1'b1;
                if (op_q == OP_RESUME) susp_q <= 1'b0;
                if (op_q == OP_DPD) dpd_q <= 1'b1;
                if (op_q == OP_RDPD) dpd_q <= 1'b0;
            end
        end
    end

    // outputs
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            nv_store       <= '0;
            nv_store_stb   <= 1'b0;
            status_word    <= '0;
            lane_mode_four <= 1'b0;
            array_op_stb   <= 1'b0;
            array_op_code  <= '0;
            array_op_addr  <= '0;
        end else begin
            nv_store_stb   <= start_wrsr;
            if (start_wrsr) nv_store <= new_nv;
            status_word    <= status_now;
            lane_mode_four <= nv_q[BIT_FOUR];
            array_op_stb   <= start_arr;
            if (start_arr) begin
                array_op_code <= op_q;
                array_op_addr <= rng_lo;
            end
        end
    end
endmodule : wp_status_core
`default_nettype wire

// *** design/wp_status_pkg.sv ***
// constants and types for the flash write-protection and status block
package wp_status_pkg;
    // status bit positions
    localparam int BIT_BUSY    = 0;
    localparam int BIT_ARMED   = 1;
    localparam int BIT_SIZE_LO = 2;
    localparam int BIT_SIZE_HI = 4;
    localparam int BIT_BOTTOM  = 5;
    localparam int BIT_SMALL   = 6;
    localparam int BIT_LOCK0   = 7;
    localparam int BIT_LOCK1   = 8;
    localparam int BIT_FOUR    = 9;
    localparam int BIT_INVERT  = 14;
    localparam int BIT_SUSP    = 15;
    // writable non-volatile bits of the 16-bit status word
    localparam logic [15:0] NV_MASK  = 16'h43fc;
    localparam logic [15:0] NV_RESET = 16'h0000;
    // instruction codes of the serial interface
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_WRDI   = 8'h04;
    localparam logic [7:0] OP_RDSR1  = 8'h05;
    localparam logic [7:0] OP_RDSR2  = 8'h35;
    localparam logic [7:0] OP_WRSR   = 8'h01;
    localparam logic [7:0] OP_PP     = 8'h02;
    localparam logic [7:0] OP_QPP    = 8'h32;
    localparam logic [7:0] OP_SE4    = 8'h20;
    localparam logic [7:0] OP_BE32   = 8'h52;
    localparam logic [7:0] OP_BE64   = 8'hd8;
    localparam logic [7:0] OP_CE     = 8'hc7;
    localparam logic [7:0] OP_WRSEC  = 8'h42;
    localparam logic [7:0] OP_SUSP   = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_DPD    = 8'hb9;
    localparam logic [7:0] OP_RDPD   = 8'hab;
    localparam logic [7:0] OP_QREAD  = 8'h6b;
    localparam logic [7:0] OP_QIOREAD= 8'heb;
    localparam logic [7:0] OP_QPI    = 8'h38;
    // lock encodings
    localparam logic [1:0] LOCK_SW   = 2'h0;
    localparam logic [1:0] LOCK_HW   = 2'h1;
    localparam logic [1:0] LOCK_PWR  = 2'h2;
    localparam logic [1:0] LOCK_OTP  = 2'h3;
    // timing
    localparam int CLK_MHZ        = 50;
    localparam int PUW_US         = 1000;
    localparam int PUW_CYC        = PUW_US * CLK_MHZ;
    localparam int BUSY_US        = 10;
    localparam int BUSY_CYC       = BUSY_US * CLK_MHZ;
    localparam int CNT_W          = 24;
    localparam int ADDR_W         = 23;
    localparam logic [ADDR_W-1:0] SEC4K_MASK  = 23'h000fff;
    localparam logic [ADDR_W-1:0] BLK32K_MASK = 23'h007fff;
    localparam logic [ADDR_W-1:0] BLK64K_MASK = 23'h00ffff;
    localparam logic [ADDR_W-1:0] ARRAY_TOP   = 23'h7fffff;
    typedef enum logic [2:0] {ST_IDLE, ST_OP, ST_ADDR, ST_DATA, ST_READ, ST_SKIP} frame_st_t;
endpackage : wp_status_pkg

// *** design/wp_sync2.sv ***
// two-flop synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module wp_sync2 (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // level in and out
    input  wire logic d,
    output var  logic q
);
    logic meta_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : wp_sync2
`default_nettype wire

// *** design/wp_region_check.sv ***
// decides whether an address range touches the protected region
`timescale 1ns/100ps
`default_nettype none
module wp_region_check
    import wp_status_pkg::*;
(
    // protection selectors
    input  wire logic [2:0]        size_bits,
    input  wire logic              bottom_select,
    input  wire logic              small_unit_select,
    input  wire logic              invert_protection,
    // requested range
    input  wire logic [ADDR_W-1:0] lo_addr,
    input  wire logic [ADDR_W-1:0] hi_addr,
    // verdict
    output logic                   hit
);
    logic [ADDR_W-1:0] span;
    logic [ADDR_W-1:0] p_lo;
    logic [ADDR_W-1:0] p_hi;
    logic              none;
    logic              all;
    always_comb begin
        none = (size_bits == 3'h0);
        all  = (size_bits == 3'h7) && !small_unit_select;
        if (small_unit_select)
            span = ADDR_W'((24'h001000 << ((size_bits[2] ? 3'h4 : {1'b0, size_bits[1:0]}) - 3'h1)) - 24'h1);
        else
            span = ADDR_W'((24'h020000 << (size_bits - 3'h1)) - 24'h1);
        if (size_bits == 3'h7 && small_unit_select) span = ARRAY_TOP;
        if (size_bits == 3'h7) all = 1'b1;
        p_lo = bottom_select ? '0 : ARRAY_TOP - span;
        p_hi = bottom_select ? span : ARRAY_TOP;
        if (all) begin
            p_lo = '0;
            p_hi = ARRAY_TOP;
        end
        if (!invert_protection)
            hit = !none && (lo_addr <= p_hi) && (hi_addr >= p_lo);
        else if (none)
            hit = 1'b1;
        else if (all)
            hit = 1'b0;
        else
            // complement: anything outside the selected region is protected
            hit = (lo_addr < p_lo) || (hi_addr > p_hi);
    end
endmodule : wp_region_check
`default_nettype wire

// *** tb/wp_status_checker.sv ***
// port assertions for the write-protection and status block
`timescale 1ns/100ps
`default_nettype none
module wp_status_checker
    import wp_status_pkg::*;
#(
    parameter int PUW_CYCLES  = 50000,
    parameter int BUSY_CYCLES = 500
) (
    // clock and reset
    input wire logic        mclk,
    input wire logic        arst_n,
    // pins and outputs watched
    input wire logic        wp_n,
    input wire logic [15:0] status_word,
    input wire logic        nv_store_stb,
    input wire logic        array_op_stb,
    input wire logic        lane_mode_four
);
    int up_q;
    int busy_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) up_q <= 0;
        else if (up_q < PUW_CYCLES + 8) up_q <= up_q + 1;
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) busy_q <= 0;
        else if (!status_word[BIT_BUSY]) busy_q <= 0;
        // suspended cycles do not count towards the operation time
        else if (!status_word[BIT_SUSP]) busy_q <= busy_q + 1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    rsvd_zero_a: assert property (status_word[13:10] == 4'h0)
        else $error("reserved status bits not zero");
    puw_hold_a: assert property (nv_store_stb || array_op_stb |-> up_q >= PUW_CYCLES)
        else $error("write before power-up delay");
    store_armed_a: assert property (nv_store_stb |-> $past(status_word[BIT_ARMED], 3))
        else $error("status stored without write latch");
    store_busy_a: assert property (nv_store_stb |-> ##[0:2] status_word[BIT_BUSY])
        else $error("status write did not raise busy");
    armed_clear_a: assert property (nv_store_stb |-> ##[0:2] !status_word[BIT_ARMED])
        else $error("write latch not cleared");
    busy_len_a: assert property ($fell(status_word[BIT_BUSY]) |->
        busy_q >= BUSY_CYCLES - 2 && busy_q <= BUSY_CYCLES + 2)
        else $error("busy length wrong");
    otp_lock_a: assert property (nv_store_stb |-> $past(status_word[8:7], 3) != LOCK_OTP)
        else $error("write under permanent lock");
    pwr_lock_a: assert property (nv_store_stb |-> $past(status_word[8:7], 3) != LOCK_PWR)
        else $error("write under power lock");
    hw_lock_a: assert property (nv_store_stb && $past(status_word[8:7], 3) == LOCK_HW
        && !$past(status_word[BIT_FOUR], 3) |-> $past(wp_n, 3)) else $error("write with pin low");
    op_idle_a: assert property (array_op_stb |-> !$past(status_word[BIT_BUSY], 3))
        else $error("array op taken while busy");
    op_armed_a: assert property (array_op_stb |-> $past(status_word[BIT_ARMED], 3))
        else $error("array op without write latch");
    lane_copy_a: assert property (lane_mode_four == status_word[BIT_FOUR])
        else $error("lane mode differs from status");
endmodule : wp_status_checker
`default_nettype wire

// *** tb/flash_host_model.sv ***
// serial host that sends instruction frames and reads status bytes
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
    // clock
    input  wire logic       mclk,
    // serial pins
    output logic            sck,
    output logic            cs_n,
    output logic            si,
    input  wire logic       so,
    // read result
    output logic            rx_stb,
    output logic [7:0]      rx_byte
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
        rx_stb = 1'b0;
        rx_byte = 8'h00;
    end
    task automatic half();
        repeat (4) @(negedge mclk);
    endtask : half
    // single lane only: four-lane enable is never requested
    task automatic frame(input logic [31:0] w, input int nb, input bit rd);
        logic [7:0] r;
        r = 8'h00;
        cs_n = 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            si = w[i];
            half();
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
        si = ~si;
        for (int i = 0; i < (rd ? 8 : 0); i++) begin
            half();
            sck = 1'b1;
            half();
            // taken late in the high phase: the output trails sck fall by several clocks
            r = {r[6:0], so};
            sck = 1'b0;
        end
        half();
        cs_n = 1'b1;
        if (rd) begin
            rx_byte = r;
            rx_stb = 1'b1;
            @(negedge mclk);
            rx_stb = 1'b0;
        end
        repeat (8 + $urandom_range(0, 8)) @(negedge mclk);
    endtask : frame
endmodule : flash_host_model
`default_nettype wire

// *** tb/flash_write_protect_status_tb_top.sv ***
// testbench for the write-protection and status block
`timescale 1ns/100ps
`default_nettype none
module flash_write_protect_status_tb_top;
    import wp_status_pkg::*;
    localparam int PUW = 400;
    localparam int BSY = 400;
    logic              mclk, arst_n, wp_n, so, so_oe, so_last, rx_stb, nv_stb, op_stb;
    logic              sck, cs_n, si;
    logic [7:0]        rx_byte, op_code, r;
    logic [15:0]       nv_image, nv_store, status_word;
    logic [ADDR_W-1:0] op_addr;
    logic [7:0]        exp_rd[$];
    logic [30:0]       exp_op[$];
    int                err_count, samples_checked, cyc;
    wp_status_core #(.PUW_CYCLES(PUW), .BUSY_CYCLES(BSY)) u_dut (
        .mclk(mclk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
        .so_oe(so_oe), .wp_n(wp_n), .hold_n(1'b1), .nv_image(nv_image),
        .nv_store(nv_store), .nv_store_stb(nv_stb), .status_word(status_word),
        .lane_mode_four(), .array_op_stb(op_stb), .array_op_code(op_code),
        .array_op_addr(op_addr));
    flash_host_model u_host (.mclk(mclk), .sck(sck), .cs_n(cs_n), .si(si),
        .so(so_oe ? so : ~so_last), .rx_stb(rx_stb), .rx_byte(rx_byte));
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        so_last <= so_oe ? so : so_last;
        if (nv_stb) nv_image <= nv_store;
        if (rx_stb) check(rx_byte, exp_rd.size() ? exp_rd.pop_front() : 'x);
        if (op_stb) check({op_code, op_addr}, exp_op.size() ? exp_op.pop_front() : 'x);
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cmd(input logic [7:0] c);
        u_host.frame({24'h0, c}, 8, 1'b0);
    endtask : cmd
    task automatic rd(input logic [7:0] c, input logic [7:0] exp);
        exp_rd.push_back(exp);
        u_host.frame({24'h0, c}, 8, 1'b1);
    endtask : rd
    task automatic wrsr(input logic [15:0] v, input bit en);
        if (en) cmd(OP_WREN);
        u_host.frame({8'h0, OP_WRSR, v[7:0], v[15:8]}, 24, 1'b0);
        repeat (BSY + 20) @(negedge mclk);
    endtask : wrsr
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        wp_n = 1'b1;
        so_last = 1'b0;
        nv_image = NV_RESET;
        err_count = 0;
        samples_checked = 0;
        cyc = 0;
        r = 8'($urandom(66611));
        arst_n = 1'b0;
        repeat (8) @(negedge mclk);
        arst_n = 1'b1;
        repeat (20) @(negedge mclk);
        cmd(OP_WREN);
        rd(OP_RDSR1, 8'h00);
        repeat (PUW) @(negedge mclk);
        cmd(OP_WREN);
        rd(OP_RDSR1, 8'h02);
        cmd(OP_WRDI);
        rd(OP_RDSR1, 8'h00);
        wrsr(16'h001c, 1'b0);
        rd(OP_RDSR1, 8'h00);
        cmd(OP_WREN);
        u_host.frame({OP_QPP, 24'h000000}, 32, 1'b0);
        for (int k = 0; k < 3; k++) begin
            r = 8'($urandom) & 8'h7c;
            cmd(OP_WREN);
            u_host.frame({8'h0, OP_WRSR, r, 2'h2, 4'($urandom), 2'h0}, 24, 1'b0);
            rd(OP_RDSR1, r | 8'h01);
            cmd(OP_WREN);
            repeat (BSY) @(negedge mclk);
            rd(OP_RDSR1, r);
            rd(OP_RDSR2, 8'h00);
        end
        cmd(OP_WREN);
        u_host.frame({8'h0, OP_WRSR, 16'h0000}, 24, 1'b0);
        cmd(OP_SUSP);
        rd(OP_RDSR2, 8'h80);
        cmd(OP_RESUME);
        repeat (BSY) @(negedge mclk);
        rd(OP_RDSR2, 8'h00);
        rd(OP_RDSR1, 8'h00);
        for (int c = 0; c < 2; c++) begin
            wrsr({1'b0, c[0], 14'h0004}, 1'b1);
            cmd(OP_WREN);
            u_host.frame({OP_SE4, c ? 24'h000000 : 24'h7ff000}, 32, 1'b0);
            exp_op.push_back({OP_SE4, c ? 23'h7ff000 : 23'h000000});
            cmd(OP_WREN);
            u_host.frame({OP_SE4, c ? 24'h7ff000 : 24'h000000}, 32, 1'b0);
            repeat (BSY + 20) @(negedge mclk);
        end
        wp_n = 1'b0;
        wrsr(16'h0080, 1'b1);
        rd(OP_RDSR1, 8'h80);
        wrsr(16'h0084, 1'b1);
        rd(OP_RDSR1, 8'h80);
        wp_n = 1'b1;
        wrsr(16'h0088, 1'b1);
        rd(OP_RDSR1, 8'h88);
        wrsr(16'h0108, 1'b1);
        wrsr(16'h0004, 1'b1);
        rd(OP_RDSR1, 8'h08);
        arst_n = 1'b0;
        cmd(OP_WREN);
        arst_n = 1'b1;
        repeat (PUW + 20) @(negedge mclk);
        rd(OP_RDSR2, 8'h00);
        rd(OP_RDSR1, 8'h08);
        wrsr(16'h0180, 1'b1);
        wrsr(16'h0000, 1'b1);
        rd(OP_RDSR2, 8'h01);
        cmd(OP_DPD);
        cmd(OP_WREN);
        cmd(OP_RDPD);
        rd(OP_RDSR1, 8'h80);
        repeat (20) @(negedge mclk);
        check(32'(exp_rd.size() + exp_op.size()), 32'h0);
        complete_run();
    end
endmodule : flash_write_protect_status_tb_top
bind wp_status_core wp_status_checker #(.PUW_CYCLES(PUW_CYCLES), .BUSY_CYCLES(BUSY_CYCLES))
    u_chk (.mclk(mclk), .arst_n(arst_n), .wp_n(wp_n), .status_word(status_word),
    .nv_store_stb(nv_store_stb), .array_op_stb(array_op_stb),
    .lane_mode_four(lane_mode_four));
`default_nettype wire
